// >>> logic/rfpgc_pkg.sv
/*
 holds register indices, field positions, reset values and codes for the
 transmit/receive front-end control block. assumes apb byte address is four
 times the register index.
*/
package rfpgc_pkg;
   // -----------------------------------------------------------
   // register indices (byte address = index * 4)
   // -----------------------------------------------------------
   localparam logic [7:0] IDX_CTRL = 8'h01;
   localparam logic [7:0] IDX_SHAPE = 8'h02;
   localparam logic [7:0] IDX_BITRATE = 8'h03;
   localparam logic [7:0] IDX_AMP_LEVEL = 8'h04;
   localparam logic [7:0] IDX_FRONT_GAIN = 8'h05;
   localparam logic [7:0] IDX_THRESHOLD = 8'h06;
   localparam logic [7:0] IDX_RX_TIMING = 8'h07;
   localparam logic [7:0] IDX_STATUS = 8'h08;
   localparam logic [7:0] IDX_OVERCURRENT = 8'h13;
   localparam logic [7:0] IDX_TUNE_FIRST = 8'h5a;
   localparam logic [7:0] IDX_TUNE_SECOND = 8'h5c;
   // -----------------------------------------------------------
   // field positions
   // -----------------------------------------------------------
   localparam int CTRL_OOK = 2;
   localparam int CTRL_CONT = 3;
   localparam int CTRL_AUTO = 4;
   localparam int CTRL_RESTART = 5;
   localparam int LVL_FIRST = 7;
   localparam int LVL_SECOND = 6;
   localparam int LVL_THIRD = 5;
   localparam int OCP_ON = 4;
   localparam int LNA_ZIN = 7;
   // -----------------------------------------------------------
   // reset values
   // -----------------------------------------------------------
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [1:0] RST_SHAPE = 2'h0;
   localparam logic [15:0] RST_BITRATE = 16'h0064;
   localparam logic [7:0] RST_AMP_LEVEL = 8'h9f;
   localparam logic [7:0] RST_FRONT_GAIN = 8'h80;
   localparam logic [7:0] RST_THRESHOLD = 8'he4;
   localparam logic [3:0] RST_RX_TIMING = 4'h0;
   localparam logic [7:0] RST_OVERCURRENT = 8'h1a;
   localparam logic [7:0] RST_TUNE_FIRST = 8'h55;
   localparam logic [7:0] RST_TUNE_SECOND = 8'h70;
   localparam logic [7:0] HP_TUNE_FIRST = 8'h5d;
   localparam logic [7:0] HP_TUNE_SECOND = 8'h7c;
   // -----------------------------------------------------------
   // codes and figures
   // -----------------------------------------------------------
   localparam logic [1:0] OPM_TX = 2'h1;
   localparam logic [1:0] OPM_RX = 2'h2;
   localparam logic [1:0] SHAPE_OFF = 2'h0; // 1: bt 1.0, 2: bt 0.5, 3: bt 0.3
   localparam logic [2:0] GAIN_AUTO = 3'h0;
   localparam logic [2:0] GAIN_MAX = 3'h1;
   localparam logic [2:0] GAIN_MIN = 3'h6;
   localparam logic signed [6:0] POUT_OFS_LOW = -7'sd18;
   localparam logic signed [6:0] POUT_OFS_COMB = -7'sd14;
   localparam logic signed [6:0] POUT_OFS_HIGH = -7'sd11;
   localparam logic [7:0] ILIM_BASE_MA = 8'h2d;
   localparam logic [7:0] ILIM_STEP_MA = 8'h05;
   localparam int GAIN_STEP_SHIFT = 4;
   typedef enum logic [1:0] {
      AGC_IDLE = 2'b00,
      AGC_WAIT = 2'b01,
      AGC_HOLD = 2'b10,
      AGC_DELAY = 2'b11
   } rfpgc_agc_e;
endpackage

// >>> logic/rfpgc_top.sv
/*
 transmit shaping, amplifier path selection, current clamp and receive
 gain sequencing, reached over apb. assumes measured strength comes from
 same-clock logic and tx data arrives asynchronously on a pin.
*/
// The APB interface to the registers is this design's own decision.
module rfpgc_top #(
   parameter int RAMP_DIV = 64
) (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic tx_data_pin, // async tx data
   output logic bit_clock_output, // next-bit pulse
   output logic mod_bit, // bit into modulator
   output logic gauss_enable, // shaping filter on
   output logic [1:0] gauss_bt_sel, // shaping code
   output logic [3:0] pa_bias, // amplifier bias level
   output logic first_amplifier_on, // first amp on
   output logic second_amplifier_on, // second amp on
   output logic third_amplifier_on, // third amp on
   output logic shared_antenna_drive, // antenna pin driven
   output logic boost_pin_drive, // boost pin driven
   output logic high_power_active, // high power mode
   output logic signed [6:0] pout_dbm, // output power dbm
   output logic ocp_enable, // current clamp on
   output logic [7:0] current_limit_ma, // clamp in ma
   output logic input_impedance_200, // 200 ohm input
   input wire logic [7:0] measured_strength, // strength sample
   input wire logic strength_valid, // sample strobe
   input wire logic fifo_empty, // rx fifo empty
   input wire logic packet_end, // packet done pulse
   output logic agc_waiting, // receiver in wait
   output logic [2:0] applied_gain // gain in use
);
   import rfpgc_pkg::*;

   if (RAMP_DIV < 1) begin : g_chk
      $error("RAMP_DIV must be at least one");
   end

   function automatic logic [2:0] gain_pick(input logic [7:0] s,
                                             input logic [7:0] t);
      logic [7:0] m;
      logic [3:0] q;
      m = s - t;
      q = m[7:GAIN_STEP_SHIFT];
      gain_pick = (q > 4'h5) ? GAIN_MIN : GAIN_MAX + q[2:0];
   endfunction

   // -----------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------
   logic [7:0] ctrl_reg;
   logic [1:0] shape_reg;
   logic [15:0] bitrate_reg;
   logic [7:0] level_reg, ocp_reg, tune1_reg, tune2_reg, thr_reg;
   logic [2:0] gsel_reg;
   logic zin_reg;
   logic [3:0] ipd_reg;
   logic [31:0] prdata_reg;
   logic restart_reg;
   rfpgc_agc_e state_reg, state_next;
   logic [7:0] last_strength_reg;

   wire [9:0] widx = paddr[11:2];
   wire hit_ctrl = (widx == {2'b00, IDX_CTRL});
   wire hit_shape = (widx == {2'b00, IDX_SHAPE});
   wire hit_br = (widx == {2'b00, IDX_BITRATE});
   wire hit_lvl = (widx == {2'b00, IDX_AMP_LEVEL});
   wire hit_lna = (widx == {2'b00, IDX_FRONT_GAIN});
   wire hit_thr = (widx == {2'b00, IDX_THRESHOLD});
   wire hit_rxt = (widx == {2'b00, IDX_RX_TIMING});
   wire hit_st = (widx == {2'b00, IDX_STATUS});
   wire hit_ocp = (widx == {2'b00, IDX_OVERCURRENT});
   wire hit_t1 = (widx == {2'b00, IDX_TUNE_FIRST});
   wire hit_t2 = (widx == {2'b00, IDX_TUNE_SECOND});
   wire mapped = hit_ctrl | hit_shape | hit_br | hit_lvl | hit_lna |
      hit_thr | hit_rxt | hit_st | hit_ocp | hit_t1 | hit_t2;
   wire wr = psel & penable & pwrite & mapped;
   wire rd_setup = psel & ~penable & ~pwrite;
   logic [31:0] rd_mux;

   always_comb begin
      if (hit_ctrl) rd_mux = {24'h0, 2'b00, 1'b0, ctrl_reg[4:0]};
      else if (hit_shape) rd_mux = {30'h0, shape_reg};
      else if (hit_br) rd_mux = {16'h0, bitrate_reg};
      else if (hit_lvl) rd_mux = {24'h0, level_reg};
      else if (hit_lna) rd_mux = {24'h0, zin_reg, 1'b0, applied_gain, gsel_reg};
      else if (hit_thr) rd_mux = {24'h0, thr_reg};
      else if (hit_rxt) rd_mux = {28'h0, ipd_reg};
      else if (hit_st) rd_mux = {21'h0, high_power_active, state_reg,
                                 last_strength_reg};
      else if (hit_ocp) rd_mux = {24'h0, ocp_reg};
      else if (hit_t1) rd_mux = {24'h0, tune1_reg};
      else if (hit_t2) rd_mux = {24'h0, tune2_reg};
      else rd_mux = 32'h0;
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= RST_CTRL;
         shape_reg <= RST_SHAPE;
         bitrate_reg <= RST_BITRATE;
         level_reg <= RST_AMP_LEVEL;
         zin_reg <= RST_FRONT_GAIN[LNA_ZIN];
         gsel_reg <= RST_FRONT_GAIN[2:0];
         thr_reg <= RST_THRESHOLD;
         ipd_reg <= RST_RX_TIMING;
         ocp_reg <= RST_OVERCURRENT;
         tune1_reg <= RST_TUNE_FIRST;
         tune2_reg <= RST_TUNE_SECOND;
         prdata_reg <= 32'h0;
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= wr & hit_ctrl & pwdata[CTRL_RESTART];
         if (rd_setup) prdata_reg <= rd_mux;
         if (wr && hit_ctrl) ctrl_reg <= {3'b000, pwdata[4:0]};
         if (wr && hit_shape) shape_reg <= pwdata[1:0];
         if (wr && hit_br) bitrate_reg <= pwdata[15:0];
         if (wr && hit_lvl) level_reg <= pwdata[7:0];
         if (wr && hit_lna) begin
            zin_reg <= pwdata[LNA_ZIN];
            gsel_reg <= pwdata[2:0];
         end
         if (wr && hit_thr) thr_reg <= pwdata[7:0];
         if (wr && hit_rxt) ipd_reg <= pwdata[3:0];
         if (wr && hit_ocp) ocp_reg <= pwdata[7:0];
         if (wr && hit_t1) tune1_reg <= pwdata[7:0];
         if (wr && hit_t2) tune2_reg <= pwdata[7:0];
      end
   end

   wire is_tx = (ctrl_reg[1:0] == OPM_TX);
   wire is_rx = (ctrl_reg[1:0] == OPM_RX);
   wire is_ook = ctrl_reg[CTRL_OOK];
   wire is_cont = ctrl_reg[CTRL_CONT];
   wire auto_receive_restart = ctrl_reg[CTRL_AUTO];

   // -----------------------------------------------------------
   // bit timing and tx data
   // -----------------------------------------------------------
   logic [15:0] bit_cnt_reg;
   logic [2:0] din_sync_reg;
   logic bclk_reg, mod_reg;
   // a zero divisor would stall the bit clock, so it acts as one
   wire [15:0] br_last = (bitrate_reg == 16'h0) ? 16'h0 : bitrate_reg - 16'h1;
   wire bit_tick = (bit_cnt_reg >= br_last);
   wire din_clean = din_sync_reg[2] & din_sync_reg[1];
   wire din_stable = (din_sync_reg[2] == din_sync_reg[1]);
   wire gauss_on = ~is_ook & (shape_reg != SHAPE_OFF);
   wire bclk_cond = bit_tick & is_tx & is_cont & gauss_on;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_reg <= 16'h0;
         din_sync_reg <= 3'b000;
         bclk_reg <= 1'b0;
         mod_reg <= 1'b0;
      end else begin
         bit_cnt_reg <= (bit_tick || !(is_tx || is_rx)) ? 16'h0 :
                        bit_cnt_reg + 16'h1;
         din_sync_reg <= {din_sync_reg[1:0], tx_data_pin};
         bclk_reg <= bclk_cond;
         // shaped continuous stream takes one bit per bit clock, else follows the pin
         if (gauss_on && is_cont) begin
            if (bclk_cond) mod_reg <= din_clean;
         end else if (din_stable) begin
            mod_reg <= din_sync_reg[2];
         end
      end
   end

   assign bit_clock_output = bclk_reg;
   assign mod_bit = mod_reg;
   assign gauss_enable = gauss_on & is_tx;
   assign gauss_bt_sel = shape_reg;

   // -----------------------------------------------------------
   // amplifier paths, power and current clamp
   // -----------------------------------------------------------
   wire [2:0] amp_sel = {level_reg[LVL_FIRST], level_reg[LVL_SECOND],
                         level_reg[LVL_THIRD]};
   wire [6:0] pwr_field = {2'b00, level_reg[4:0]};
   wire hp_loaded = (tune1_reg == HP_TUNE_FIRST) &&
                    (tune2_reg == HP_TUNE_SECOND);
   wire m_first = (amp_sel == 3'b100);
   wire m_second = (amp_sel == 3'b010);
   wire m_comb = (amp_sel == 3'b011);
   logic signed [6:0] pout_next;
   logic [7:0] ilim_next;
   logic fa_reg, sa_reg, ta_reg, ant_reg, bst_reg, hp_reg, ocp_on_reg;
   logic signed [6:0] pout_reg;
   logic [7:0] ilim_reg;

   always_comb begin
      if (m_comb && hp_loaded) pout_next = POUT_OFS_HIGH + pwr_field;
      else if (m_comb) pout_next = POUT_OFS_COMB + pwr_field;
      else pout_next = POUT_OFS_LOW + pwr_field;
      ilim_next = ILIM_BASE_MA + 8'(ILIM_STEP_MA * {4'h0, ocp_reg[3:0]});
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {fa_reg, sa_reg, ta_reg, ant_reg, bst_reg, hp_reg} <= 6'h0;
         ocp_on_reg <= 1'b0;
         pout_reg <= 7'sd0;
         ilim_reg <= 8'h0;
      end else begin
         // reserved enable patterns switch every path off
         fa_reg <= is_tx & m_first;
         sa_reg <= is_tx & (m_second | m_comb);
         ta_reg <= is_tx & m_comb;
         ant_reg <= is_tx & m_first;
         bst_reg <= is_tx & (m_second | m_comb);
         hp_reg <= m_comb & hp_loaded;
         pout_reg <= pout_next;
         ocp_on_reg <= ocp_reg[OCP_ON];
         ilim_reg <= ilim_next;
      end
   end

   assign first_amplifier_on = fa_reg;
   assign second_amplifier_on = sa_reg;
   assign third_amplifier_on = ta_reg;
   assign shared_antenna_drive = ant_reg;
   assign boost_pin_drive = bst_reg;
   assign high_power_active = hp_reg;
   assign pout_dbm = pout_reg;
   assign ocp_enable = ocp_on_reg;
   assign current_limit_ma = ilim_reg;
   assign input_impedance_200 = zin_reg;

   // -----------------------------------------------------------
   // ook bias ramp
   // -----------------------------------------------------------
   logic [15:0] ramp_cnt_reg;
   logic [3:0] bias_reg;
   wire amp_on = is_tx & (m_first | m_second | m_comb);
   wire [3:0] bias_goal = (amp_on && (!is_ook || mod_reg)) ? 4'hf : 4'h0;
   wire ramp_mode = is_ook & (shape_reg != SHAPE_OFF);
   wire ramp_tick = (ramp_cnt_reg >= 16'(RAMP_DIV - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_cnt_reg <= 16'h0;
         bias_reg <= 4'h0;
      end else begin
         ramp_cnt_reg <= ramp_tick ? 16'h0 : ramp_cnt_reg + 16'h1;
         if (!ramp_mode) bias_reg <= bias_goal;
         else if (ramp_tick && bias_reg < bias_goal)
            bias_reg <= bias_reg + 4'h1;
         else if (ramp_tick && bias_reg > bias_goal)
            bias_reg <= bias_reg - 4'h1;
      end
   end

   assign pa_bias = bias_reg;

   // -----------------------------------------------------------
   // receive gain sequence
   // -----------------------------------------------------------
   logic above_cnt_reg, pend_reg;
   logic [2:0] held_reg, gain_reg;
   logic [15:0] dly_cnt_reg;
   wire above = strength_valid & (measured_strength > thr_reg);
   wire manual = (gsel_reg != GAIN_AUTO) && (gsel_reg <= GAIN_MIN);
   wire [15:0] dly_last = (16'h1 << ipd_reg) - 16'h1;
   wire dly_done = bit_tick && (dly_cnt_reg >= dly_last);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         AGC_IDLE: state_next = AGC_WAIT;
         AGC_WAIT: if (above && above_cnt_reg) state_next = AGC_HOLD;
         AGC_HOLD: if (!is_cont && auto_receive_restart && pend_reg &&
                       fifo_empty) state_next = AGC_DELAY;
         AGC_DELAY: if (dly_done) state_next = AGC_WAIT;
         default: state_next = AGC_IDLE;
      endcase
      if (restart_reg) state_next = AGC_WAIT;
      if (!is_rx) state_next = AGC_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= AGC_IDLE;
         above_cnt_reg <= 1'b0;
         pend_reg <= 1'b0;
         held_reg <= GAIN_MAX;
         gain_reg <= GAIN_MAX;
         dly_cnt_reg <= 16'h0;
         last_strength_reg <= 8'h0;
      end else begin
         state_reg <= state_next;
         if (strength_valid) last_strength_reg <= measured_strength;
         if (state_reg != AGC_WAIT) above_cnt_reg <= 1'b0;
         else if (strength_valid) above_cnt_reg <= above;
         if (state_reg == AGC_WAIT && state_next == AGC_HOLD)
            held_reg <= gain_pick(measured_strength, thr_reg);
         // packet end arriving with the leaving edge is kept
         if (packet_end && state_reg == AGC_HOLD) pend_reg <= 1'b1;
         else if (state_next != AGC_HOLD) pend_reg <= 1'b0;
         dly_cnt_reg <= (state_reg != AGC_DELAY) ? 16'h0 :
                        (bit_tick ? dly_cnt_reg + 16'h1 : dly_cnt_reg);
         if (manual) gain_reg <= gsel_reg;
         else if (state_reg == AGC_HOLD || state_reg == AGC_DELAY)
            gain_reg <= held_reg;
         else gain_reg <= GAIN_MAX;
      end
   end

   assign agc_waiting = (state_reg == AGC_WAIT);
   assign applied_gain = gain_reg;

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   property p_bit_clock;
      @(posedge pclk) disable iff (!presetn)
      bit_clock_output |-> $past(is_tx) && $past(gauss_on) && $past(is_cont);
   endproperty
   a_bit_clock: assert property (p_bit_clock) else $error("bad bit clock");
   property p_ramp;
      @(posedge pclk) disable iff (!presetn)
      (ramp_mode && $past(ramp_mode) && !$past(ramp_tick)) |->
         $stable(pa_bias);
   endproperty
   a_ramp: assert property (p_ramp) else $error("bias stepped");
   property p_first;
      @(posedge pclk) disable iff (!presetn)
      (is_tx && m_first) |=> shared_antenna_drive && !boost_pin_drive &&
         pout_dbm == POUT_OFS_LOW + $past(pwr_field);
   endproperty
   a_first: assert property (p_first) else $error("first path wrong");
   property p_second;
      @(posedge pclk) disable iff (!presetn)
      (is_tx && m_second) |=> boost_pin_drive && !third_amplifier_on &&
         pout_dbm == POUT_OFS_LOW + $past(pwr_field);
   endproperty
   a_second: assert property (p_second) else $error("second path wrong");
   property p_comb;
      @(posedge pclk) disable iff (!presetn)
      (is_tx && m_comb && !hp_loaded) |=> third_amplifier_on &&
         pout_dbm == POUT_OFS_COMB + $past(pwr_field);
   endproperty
   a_comb: assert property (p_comb) else $error("combined wrong");
   property p_high;
      @(posedge pclk) disable iff (!presetn)
      (m_comb && hp_loaded) |=> high_power_active &&
         pout_dbm == POUT_OFS_HIGH + $past(pwr_field);
   endproperty
   a_high: assert property (p_high) else $error("high power wrong");
   property p_ilim;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> current_limit_ma == 8'd45 + 8'd5 * {4'h0, $past(ocp_reg[3:0])};
   endproperty
   a_ilim: assert property (p_ilim) else $error("current limit wrong");
   property p_manual;
      @(posedge pclk) disable iff (!presetn)
      manual ##1 manual |-> applied_gain == $past(gsel_reg);
   endproperty
   a_manual: assert property (p_manual) else $error("manual gain lost");
   property p_wait;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == AGC_WAIT ##1 state_reg == AGC_HOLD) |->
         $past(strength_valid) &&
         ($past(measured_strength) > $past(thr_reg));
   endproperty
   a_wait: assert property (p_wait) else $error("left wait early");
   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == AGC_HOLD && is_rx && !restart_reg &&
       !auto_receive_restart) |=> state_reg == AGC_HOLD && $stable(held_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("gain not held");
   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      (restart_reg && is_rx) |=> agc_waiting;
   endproperty
   a_restart: assert property (p_restart) else $error("restart ignored");
   c_hold: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == AGC_WAIT ##1 state_reg == AGC_HOLD);
   c_delay: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == AGC_DELAY ##1 state_reg == AGC_WAIT);
   c_hp: cover property (@(posedge pclk) disable iff (!presetn)
      high_power_active && boost_pin_drive);
   c_bclk: cover property (@(posedge pclk) disable iff (!presetn)
      bit_clock_output);
endmodule

// >>> dv/rfpgc_host_model.sv
/*
 host side partner: strength samples, packet ends, fifo state, tx pin.
 assumes it shares pclk with the block and acts just after an edge.
*/
module rfpgc_host_model (
   input wire logic pclk, // bus clock
   output logic [7:0] measured_strength, // strength sample
   output logic strength_valid, // sample strobe
   output logic fifo_empty, // rx fifo empty
   output logic packet_end, // packet done pulse
   output logic tx_data_pin // tx data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      measured_strength = 8'h00;
      strength_valid = 1'b0;
      fifo_empty = 1'b0;
      packet_end = 1'b0;
      tx_data_pin = 1'b0;
   end
   // one level strobed valid for a single clock, as a preamble would give it
   task automatic sample(input logic [7:0] s);
      @(posedge pclk);
      measured_strength <= s;
      strength_valid <= 1'b1;
      @(posedge pclk);
      strength_valid <= 1'b0;
      // stale value must not look valid
      measured_strength <= ~s;
   endtask
   task automatic pkt();
      @(posedge pclk);
      packet_end <= 1'b1;
      @(posedge pclk);
      packet_end <= 1'b0;
   endtask
endmodule

// >>> dv/rfpgc_tb_top.sv
/*
 bench: apb master, amplifier table, then gain, shaping and ramp cases.
 assumes zero wait apb and the host model on the receive inputs.
*/
module rfpgc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rfpgc_pkg::*;
   typedef struct packed {
      logic [7:0] lvl, t1, t2, ocp;
      logic [6:0] pout;
      logic [1:0] drv;
      logic hp;
   } rfpgc_row_s;
   rfpgc_row_s rows [5] = '{'{8'h85, 8'h55, 8'h70, 8'h1a, 7'h73, 2'b10, 1'b0},
      '{8'h4f, 8'h55, 8'h70, 8'h1b, 7'h7d, 2'b01, 1'b0},
      '{8'h7f, 8'h55, 8'h70, 8'h1f, 7'h11, 2'b01, 1'b0},
      '{8'h7f, 8'h5d, 8'h7c, 8'h0f, 7'h14, 2'b01, 1'b1},
      '{8'h60, 8'h5d, 8'h7c, 8'h0f, 7'h75, 2'b01, 1'b1}};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, err, pready, pslverr, bit_clock_output;
   logic gauss_enable, boost_pin_drive, shared_antenna_drive, ocp_enable;
   logic high_power_active, input_impedance_200, agc_waiting, tx_data_pin;
   logic strength_valid, fifo_empty, packet_end;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] gauss_bt_sel;
   logic [3:0] pa_bias;
   logic [6:0] pout_dbm;
   logic [7:0] current_limit_ma, measured_strength;
   logic [2:0] applied_gain;
   logic mod_bit, first_amplifier_on, second_amplifier_on, third_amplifier_on;
   int n_errors = 0, checks_done = 0, n;
   rfpgc_top #(.RAMP_DIV(2)) rfpgc_top_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .tx_data_pin, .bit_clock_output, .mod_bit, .gauss_enable,
      .gauss_bt_sel, .pa_bias, .first_amplifier_on,
      .second_amplifier_on, .third_amplifier_on,
      .shared_antenna_drive, .boost_pin_drive, .high_power_active,
      .pout_dbm, .ocp_enable, .current_limit_ma, .input_impedance_200,
      .measured_strength, .strength_valid, .fifo_empty, .packet_end,
      .agc_waiting, .applied_gain);
   rfpgc_host_model rfpgc_host_model_inst (.pclk, .measured_strength,
      .strength_valid, .fifo_empty, .packet_end, .tx_data_pin);
   initial forever #5 pclk = ~pclk;
   task automatic end_of_test();
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, a, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (3) @(posedge pclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk({29'h0, applied_gain}, 32'h1);
      rdc(IDX_OVERCURRENT, RST_OVERCURRENT);
      rdc(IDX_TUNE_FIRST, RST_TUNE_FIRST);
      rdc(IDX_TUNE_SECOND, RST_TUNE_SECOND);
      apb(1'b0, 8'h30, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      wr(IDX_CTRL, 32'h1);
      foreach (rows[k]) begin
         wr(IDX_OVERCURRENT, {24'h0, rows[k].ocp});
         wr(IDX_TUNE_FIRST, {24'h0, rows[k].t1});
         wr(IDX_TUNE_SECOND, {24'h0, rows[k].t2});
         wr(IDX_AMP_LEVEL, {24'h0, rows[k].lvl});
         chk({25'h0, pout_dbm}, {25'h0, rows[k].pout});
         chk({shared_antenna_drive, boost_pin_drive, high_power_active},
             {rows[k].drv, rows[k].hp});
         chk({first_amplifier_on, second_amplifier_on, third_amplifier_on},
             rows[k].lvl[7:5]);
         chk({ocp_enable, current_limit_ma},
             {rows[k].ocp[4], 8'(45 + 5 * rows[k].ocp[3:0])});
         rdc(IDX_AMP_LEVEL, {24'h0, rows[k].lvl});
      end
      wr(IDX_OVERCURRENT, {24'h0, RST_OVERCURRENT});
      wr(IDX_TUNE_FIRST, {24'h0, RST_TUNE_FIRST});
      wr(IDX_TUNE_SECOND, {24'h0, RST_TUNE_SECOND});
      chk({31'h0, high_power_active}, 32'h0);
      wr(IDX_CTRL, 32'h2);
      for (int g = 1; g <= 6; g++) begin
         wr(IDX_FRONT_GAIN, 32'h80 | g);
         chk({29'h0, applied_gain}, g);
      end
      chk({31'h0, input_impedance_200}, 32'h1);
      rdc(IDX_FRONT_GAIN, 32'hb6);
      wr(IDX_FRONT_GAIN, 32'h0);
      wr(IDX_THRESHOLD, 32'h40);
      wr(IDX_CTRL, 32'h22);
      chk({input_impedance_200, agc_waiting}, 32'h1);
      rfpgc_host_model_inst.sample(8'h50);
      rfpgc_host_model_inst.sample(8'h40);
      rfpgc_host_model_inst.sample(8'h60);
      repeat (3) @(posedge pclk);
      chk({31'h0, agc_waiting}, 32'h1);
      rfpgc_host_model_inst.sample(8'h60);
      repeat (3) @(posedge pclk);
      chk({agc_waiting, applied_gain}, 32'h3);
      rfpgc_host_model_inst.pkt();
      repeat (5) @(posedge pclk);
      chk({agc_waiting, applied_gain}, 32'h3);
      wr(IDX_CTRL, 32'h22);
      chk({31'h0, agc_waiting}, 32'h1);
      wr(IDX_BITRATE, 32'h4);
      wr(IDX_CTRL, 32'h12);
      rfpgc_host_model_inst.sample(8'h60);
      rfpgc_host_model_inst.sample(8'h60);
      rfpgc_host_model_inst.pkt();
      repeat (20) @(posedge pclk);
      chk({31'h0, agc_waiting}, 32'h0);
      rfpgc_host_model_inst.fifo_empty <= 1'b1;
      rfpgc_host_model_inst.pkt();
      for (int i = 0; i < 100 && agc_waiting !== 1'b1; i++)
         @(posedge pclk);
      chk({31'h0, agc_waiting}, 32'h1);
      for (int s = 0; s < 4; s++) begin
         wr(IDX_CTRL, 32'h0);
         wr(IDX_SHAPE, s);
         wr(IDX_CTRL, 32'h9);
         chk({gauss_enable, gauss_bt_sel}, {s != 0, 2'(s)});
      end
      for (int i = 0; i < 20 && bit_clock_output !== 1'b1; i++)
         @(posedge pclk);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (bit_clock_output !== 1'b1 && n < 20);
      chk(n, 32'h4);
      wr(IDX_CTRL, 32'h0);
      wr(IDX_AMP_LEVEL, 32'h9f);
      wr(IDX_SHAPE, 32'h1);
      rfpgc_host_model_inst.tx_data_pin <= 1'b1;
      wr(IDX_CTRL, 32'h5);
      for (int i = 0; i < 50 && pa_bias === 4'h0; i++)
         @(posedge pclk);
      chk({28'h0, pa_bias}, 32'h1);
      chk({31'h0, mod_bit}, 32'h1);
      rfpgc_host_model_inst.tx_data_pin <= 1'b0;
      for (int i = 0; i < 100 && pa_bias !== 4'h0; i++)
         @(posedge pclk);
      chk({28'h0, pa_bias}, 32'h0);
      chk({31'h0, mod_bit}, 32'h0);
      end_of_test();
   end
endmodule
